// [mac_pkg.sv]
package mac_pkg;
  // ***************************************************************
  // widths and section layout
  // ***************************************************************
  localparam int OPW     = 8;   // operand width
  localparam int PRODW   = 16;  // full product width
  localparam int ACCW    = 19;  // accumulator width
  localparam int BYTEW   = 8;   // byte section width
  localparam int EXTW    = 3;   // extension section width
  localparam int LOW_LSB = 0;   // lower byte section position
  localparam int MID_LSB = 8;   // upper byte section position
  localparam int EXT_LSB = 16;  // extension bits position

  // section indices in the drive enable vector
  localparam int SEC_LOW = 0;
  localparam int SEC_MID = 1;
  localparam int SEC_EXT = 2;
  localparam int NSEC    = 3;

  // rounding constant: one at the top bit of the lower product byte
  localparam logic [ACCW-1:0] ROUND_ADD = 19'h00080;

  // reset values
  localparam logic [ACCW-1:0] ACC_RST  = 19'h00000;
  localparam logic [OPW-1:0]  OPND_RST = 8'h00;
  localparam logic [NSEC-1:0] OEN_RST  = 3'h7;

  // ***************************************************************
  // accumulator modes, one-hot
  // ***************************************************************
  typedef enum logic [2:0] {
    MAC_LOAD = 3'b001,
    MAC_ADD  = 3'b010,
    MAC_SUB  = 3'b100
  } mac_mode_t;
endpackage : mac_pkg

// [mac_edge.sv]
module mac_edge
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // strobe level and its rising edge
  input  wire logic level,
  output logic      rise
);
  typedef struct packed {
    logic prev;
  } mac_edge_st_t;

  mac_edge_st_t st_q;
  mac_edge_st_t st_d;

  // remember last sampled level
  always_comb begin
    st_d      = st_q;
    st_d.prev = level;
  end

  // starts low so a strobe already high after reset counts once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = level & ~st_q.prev;
endmodule : mac_edge

// [mac_product.sv]
module mac_product
  import mac_pkg::*;
(
  // captured operands and controls
  input  wire logic [mac_pkg::OPW-1:0]  a,
  input  wire logic [mac_pkg::OPW-1:0]  b,
  input  wire logic                     is_signed,
  input  wire logic                     round,
  // product extended to accumulator width
  output logic      [mac_pkg::ACCW-1:0] prod
);
  logic [PRODW-1:0] raw;
  logic [ACCW-1:0]  ext;

  // full 16-bit product, two's complement or unsigned
  always_comb begin
    if (is_signed) begin
      raw = PRODW'($signed(a) * $signed(b));
    end else begin
      raw = PRODW'(a * b);
    end
  end

  // sign or zero extension to 19 bits
  assign ext = is_signed ? {{(ACCW-PRODW){raw[PRODW-1]}}, raw}
                         : {{(ACCW-PRODW){1'b0}}, raw};

  // rounding done after extension so it can never wrap the product
  assign prod = round ? ACCW'(ext + ROUND_ADD) : ext;
endmodule : mac_product

// [mac_top.sv]
// Summary of operation
// - multiply two bytes into full 16-bit product
// - 19-bit accumulation, product sign or zero extended
// - operand registers load on their own strobe
// - controls load on first rise of either strobe, not on a second while the other is high
// - signed select chooses two's complement or unsigned
// - rounding adds one at bit seven
// - sum mode adds product to accumulator
// - sum and minus: product minus accumulator
// - sum mode low loads product directly
// - lower and upper byte sections, eight bits
// - top section holds three extension bits
// - each section has own active-low drive enable
// - preload captures pins of disabled sections
// - enabled sections drive, disabled ones float
// - no pins driven while preloading
module mac_top
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RESET_N,
  // operands and their strobes
  input  wire logic [mac_pkg::OPW-1:0]    A_DATA,
  input  wire logic [mac_pkg::OPW-1:0]    B_DATA,
  input  wire logic                       A_STROBE,
  input  wire logic                       B_STROBE,
  // controls captured with either operand
  input  wire logic                       ROUND_HALF_LSB,
  input  wire logic                       SIGNED_OPERAND_SELECT,
  input  wire logic                       SUM_MODE_ENABLE,
  input  wire logic                       MINUS_SELECT,
  // result strobe and pin control
  input  wire logic                       RESULT_STROBE,
  input  wire logic                       LOAD_FROM_PINS,
  input  wire logic                       UPPER_BITS_DRIVE_N,
  input  wire logic                       MIDDLE_BYTE_DRIVE_N,
  input  wire logic                       LOW_BYTE_DRIVE_N,
  // extension bits pins
  input  wire logic [mac_pkg::EXTW-1:0]   EXT_BITS_IN,
  output logic      [mac_pkg::EXTW-1:0]   EXT_BITS_OUT,
  output logic                            EXT_BITS_OE_N,
  // upper byte section pins
  input  wire logic [mac_pkg::BYTEW-1:0]  UPPER_BYTE_SECTION_IN,
  output logic      [mac_pkg::BYTEW-1:0]  UPPER_BYTE_SECTION_OUT,
  output logic                            UPPER_BYTE_SECTION_OE_N,
  // lower byte section pins
  input  wire logic [mac_pkg::BYTEW-1:0]  LOWER_BYTE_SECTION_IN,
  output logic      [mac_pkg::BYTEW-1:0]  LOWER_BYTE_SECTION_OUT,
  output logic                            LOWER_BYTE_SECTION_OE_N
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [OPW-1:0]  a;
    logic [OPW-1:0]  b;
    logic            round;
    logic            is_signed;
    logic            sum;
    logic            minus;
    logic [ACCW-1:0] acc;
    logic [NSEC-1:0] oe_n;
  } mac_state_t;

  mac_state_t      st_q;
  mac_state_t      st_d;
  logic            a_rise;
  logic            b_rise;
  logic            or_rise;
  logic            r_rise;
  logic [ACCW-1:0] prod;
  logic [ACCW-1:0] pins;
  logic [NSEC-1:0] drive_n;
  mac_mode_t       mode;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // accumulator mode from captured controls
  function automatic mac_mode_t mode_of(input logic sum, input logic minus);
    if (!sum) begin
      return MAC_LOAD;
    end else if (minus) begin
      return MAC_SUB;
    end
    return MAC_ADD;
  endfunction : mode_of

  // bit mask of sections picked by a per-section flag vector
  function automatic logic [ACCW-1:0] sec_mask(input logic [NSEC-1:0] sel);
    logic [ACCW-1:0] m;
    m = '0;
    m[LOW_LSB +: BYTEW] = {BYTEW{sel[SEC_LOW]}};
    m[MID_LSB +: BYTEW] = {BYTEW{sel[SEC_MID]}};
    m[EXT_LSB +: EXTW]  = {EXTW{sel[SEC_EXT]}};
    return m;
  endfunction : sec_mask

  // ***************************************************************
  // strobe edges
  // ***************************************************************
  // strobes are plain inputs sampled on the system clock
  mac_edge u_edge_a (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .level (A_STROBE),
    .rise  (a_rise)
  );

  mac_edge u_edge_b (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .level (B_STROBE),
    .rise  (b_rise)
  );

  // edge of the OR, not OR of edges: b rising while a high is no edge
  mac_edge u_edge_or (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .level (A_STROBE | B_STROBE),
    .rise  (or_rise)
  );

  mac_edge u_edge_r (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .level (RESULT_STROBE),
    .rise  (r_rise)
  );

  // ***************************************************************
  // product
  // ***************************************************************
  mac_product u_prod (
    .a         (st_q.a),
    .b         (st_q.b),
    .is_signed (st_q.is_signed),
    .round     (st_q.round),
    .prod      (prod)
  );

  // gather pins and enables into accumulator order
  assign pins    = {EXT_BITS_IN, UPPER_BYTE_SECTION_IN, LOWER_BYTE_SECTION_IN};
  assign drive_n = {UPPER_BITS_DRIVE_N, MIDDLE_BYTE_DRIVE_N, LOW_BYTE_DRIVE_N};
  assign mode    = mode_of(st_q.sum, st_q.minus);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    // operand registers, each on its own strobe
    if (a_rise) begin
      st_d.a = A_DATA;
    end
    if (b_rise) begin
      st_d.b = B_DATA;
    end
    // controls ride the first rise of either strobe
    if (or_rise) begin
      st_d.round     = ROUND_HALF_LSB;
      st_d.is_signed = SIGNED_OPERAND_SELECT;
      st_d.sum       = SUM_MODE_ENABLE;
      st_d.minus     = MINUS_SELECT;
    end
    // accumulator only moves on the result strobe
    if (r_rise) begin
      if (LOAD_FROM_PINS) begin
        // driven-off sections take their pins, the rest keep
        st_d.acc = (st_q.acc & ~sec_mask(drive_n))
                 | (pins & sec_mask(drive_n));
      end else begin
        unique case (mode)
          MAC_LOAD: st_d.acc = prod;
          MAC_ADD:  st_d.acc = ACCW'(st_q.acc + prod);
          MAC_SUB:  st_d.acc = ACCW'(prod - st_q.acc);
        endcase
      end
    end
    // drive only when not preloading and enable is low
    st_d.oe_n = drive_n | {NSEC{LOAD_FROM_PINS}};
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // reset value is a convenience only; software must load first
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q.a         <= OPND_RST;
      st_q.b         <= OPND_RST;
      st_q.round     <= 1'b0;
      st_q.is_signed <= 1'b0;
      st_q.sum       <= 1'b0;
      st_q.minus     <= 1'b0;
      st_q.acc       <= ACC_RST;
      st_q.oe_n      <= OEN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // outputs, straight from flip-flops
  // ***************************************************************
  // enables lag the pin controls by one clock, a registered-output cost
  assign EXT_BITS_OUT            = st_q.acc[EXT_LSB +: EXTW];
  assign UPPER_BYTE_SECTION_OUT  = st_q.acc[MID_LSB +: BYTEW];
  assign LOWER_BYTE_SECTION_OUT  = st_q.acc[LOW_LSB +: BYTEW];
  assign EXT_BITS_OE_N           = st_q.oe_n[SEC_EXT];
  assign UPPER_BYTE_SECTION_OE_N = st_q.oe_n[SEC_MID];
  assign LOWER_BYTE_SECTION_OE_N = st_q.oe_n[SEC_LOW];

  // ***************************************************************
  // checks
  // ***************************************************************
  operand_a_cap_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    a_rise |=> st_q.a == $past(A_DATA))
    else $error("operand a not captured on its strobe");

  operand_b_hold_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !b_rise |=> $stable(st_q.b))
    else $error("operand b changed without its strobe");

  ctrl_capture_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    or_rise |=> st_q.sum == $past(SUM_MODE_ENABLE)
             && st_q.minus == $past(MINUS_SELECT)
             && st_q.round == $past(ROUND_HALF_LSB))
    else $error("controls not captured on operand strobe");

  unsigned_ext_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !st_q.is_signed |-> prod[EXT_LSB +: EXTW] == '0)
    else $error("unsigned product not zero extended");

  load_mode_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && !LOAD_FROM_PINS && !st_q.sum |=> st_q.acc == $past(prod))
    else $error("direct load did not store product");

  add_mode_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && !LOAD_FROM_PINS && st_q.sum && !st_q.minus
    |=> st_q.acc == ACCW'($past(st_q.acc) + $past(prod)))
    else $error("accumulate add wrong");

  sub_mode_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && !LOAD_FROM_PINS && st_q.sum && st_q.minus
    |=> st_q.acc == ACCW'($past(prod) - $past(st_q.acc)))
    else $error("accumulate subtract wrong");

  preload_low_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && LOAD_FROM_PINS |=> LOWER_BYTE_SECTION_OUT
      == ($past(LOW_BYTE_DRIVE_N) ? $past(LOWER_BYTE_SECTION_IN)
                                  : $past(LOWER_BYTE_SECTION_OUT)))
    else $error("lower byte preload wrong");

  acc_hold_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !r_rise |=> $stable(st_q.acc))
    else $error("accumulator moved without result strobe");

  preload_float_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    LOAD_FROM_PINS |=> EXT_BITS_OE_N && UPPER_BYTE_SECTION_OE_N
                       && LOWER_BYTE_SECTION_OE_N)
    else $error("pins driven during preload");

  drive_upper_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !LOAD_FROM_PINS |=> UPPER_BYTE_SECTION_OE_N == $past(MIDDLE_BYTE_DRIVE_N))
    else $error("upper byte drive does not follow enable");

  sect_drive_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !LOAD_FROM_PINS |=> EXT_BITS_OE_N == $past(UPPER_BITS_DRIVE_N)
                       && LOWER_BYTE_SECTION_OE_N == $past(LOW_BYTE_DRIVE_N))
    else $error("section drive does not follow its enable");

  preload_mid_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && LOAD_FROM_PINS |=> UPPER_BYTE_SECTION_OUT
      == ($past(MIDDLE_BYTE_DRIVE_N) ? $past(UPPER_BYTE_SECTION_IN)
                                     : $past(UPPER_BYTE_SECTION_OUT)))
    else $error("upper byte preload wrong");

  preload_ext_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    r_rise && LOAD_FROM_PINS |=> EXT_BITS_OUT
      == ($past(UPPER_BITS_DRIVE_N) ? $past(EXT_BITS_IN)
                                    : $past(EXT_BITS_OUT)))
    else $error("extension bits preload wrong");

  ctrl_hold_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !or_rise |=> $stable({st_q.round, st_q.is_signed, st_q.sum, st_q.minus}))
    else $error("controls changed without a strobe edge");

  signed_cap_a: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    or_rise |=> st_q.is_signed == $past(SIGNED_OPERAND_SELECT))
    else $error("signed select not captured");
endmodule : mac_top

// [mac_host_pins.sv]
module mac_host_pins
  import mac_pkg::*;
(
  // device side of the result pins
  input  wire logic [mac_pkg::ACCW-1:0] dev_out,
  input  wire logic [mac_pkg::NSEC-1:0] dev_oe_n,
  // host preload control
  input  wire logic                     prel,
  input  wire logic [mac_pkg::NSEC-1:0] drive_n,
  input  wire logic [mac_pkg::ACCW-1:0] host_val,
  // resolved pin levels
  output logic      [mac_pkg::ACCW-1:0] pin
);

  // ***************************************************************
  // pin resolution
  // ***************************************************************
  // section that owns a given accumulator bit
  function automatic int sec_of(input int i);
    return (i >= EXT_LSB) ? SEC_EXT : (i >= MID_LSB) ? SEC_MID : SEC_LOW;
  endfunction : sec_of

  // host drives only disabled sections while preloading
  always_comb begin
    for (int i = 0; i < ACCW; i++) begin
      if (!dev_oe_n[sec_of(i)])
        pin[i] = dev_out[i];
      else if (prel && drive_n[sec_of(i)])
        pin[i] = host_val[i];
      else
        pin[i] = ~host_val[i];  // floating line must not look like data
    end
  end
endmodule : mac_host_pins

// [mult_accumulator_8x8_test.sv]
module mult_accumulator_8x8_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mac_pkg::*;

  // ***************************************************************
  // stimulus, model state and counters
  // ***************************************************************
  logic            ref_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [OPW-1:0]  a_data  = 8'h00;
  logic [OPW-1:0]  b_data  = 8'h00;
  logic            a_stb   = 1'b0;
  logic            b_stb   = 1'b0;
  logic            rnd     = 1'b0;
  logic            sgn     = 1'b0;
  logic            sum     = 1'b0;
  logic            minus   = 1'b0;
  logic            res_stb = 1'b0;
  logic            prel    = 1'b0;
  logic [NSEC-1:0] drive_n = 3'h0;
  logic [ACCW-1:0] host_val = 19'h00000;
  wire  [ACCW-1:0] pin;
  wire  [ACCW-1:0] dev_out;
  wire  [NSEC-1:0] oe_n;
  logic [ACCW-1:0] m_acc = 19'h00000;
  logic [OPW-1:0]  m_a = 8'h00;
  logic [OPW-1:0]  m_b = 8'h00;
  logic [3:0]      m_ctl = 4'h0;
  int              n_mismatch = 0;
  int              n_tests = 0;

  // free-running clock
  always #5 ref_clk = ~ref_clk;

  mac_top dut_u (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .A_DATA(a_data), .B_DATA(b_data),
    .A_STROBE(a_stb), .B_STROBE(b_stb), .ROUND_HALF_LSB(rnd), .SIGNED_OPERAND_SELECT(sgn),
    .SUM_MODE_ENABLE(sum), .MINUS_SELECT(minus), .RESULT_STROBE(res_stb),
    .LOAD_FROM_PINS(prel), .UPPER_BITS_DRIVE_N(drive_n[SEC_EXT]),
    .MIDDLE_BYTE_DRIVE_N(drive_n[SEC_MID]), .LOW_BYTE_DRIVE_N(drive_n[SEC_LOW]),
    .EXT_BITS_IN(pin[18:16]), .EXT_BITS_OUT(dev_out[18:16]), .EXT_BITS_OE_N(oe_n[SEC_EXT]),
    .UPPER_BYTE_SECTION_IN(pin[15:8]), .UPPER_BYTE_SECTION_OUT(dev_out[15:8]),
    .UPPER_BYTE_SECTION_OE_N(oe_n[SEC_MID]), .LOWER_BYTE_SECTION_IN(pin[7:0]),
    .LOWER_BYTE_SECTION_OUT(dev_out[7:0]), .LOWER_BYTE_SECTION_OE_N(oe_n[SEC_LOW]));

  mac_host_pins host_u (.dev_out(dev_out), .dev_oe_n(oe_n), .prel(prel),
                        .drive_n(drive_n), .host_val(host_val), .pin(pin));

  // ***************************************************************
  // compare, drive and model tasks
  // ***************************************************************
  task automatic chk_acc(input logic [ACCW-1:0] exp);
    n_tests++;
    if (dev_out !== exp) begin
      n_mismatch++;
      $display("Error at %0t: accumulator %h, expected %h", $time, dev_out, exp);
    end
  endtask : chk_acc

  task automatic chk_oe(input logic [NSEC-1:0] exp);
    n_tests++;
    if (oe_n !== exp) begin
      n_mismatch++;
      $display("Error at %0t: drive enables %b, expected %b", $time, oe_n, exp);
    end
  endtask : chk_oe

  // expected accumulator from captured operands and controls
  function automatic logic [ACCW-1:0] next_acc();
    logic [ACCW-1:0] p;
    p = m_ctl[2] ? {{11{m_a[7]}}, m_a} * {{11{m_b[7]}}, m_b} : {11'h000, m_a} * {11'h000, m_b};
    if (m_ctl[3])
      p = p + 19'h00080;
    return !m_ctl[1] ? p : m_ctl[0] ? p - m_acc : m_acc + p;
  endfunction : next_acc

  // one result strobe pulse; outputs settle one edge later
  task automatic pulse_result(input logic [ACCW-1:0] exp);
    @(negedge ref_clk);
    res_stb = 1'b1;
    @(negedge ref_clk);
    res_stb = 1'b0;
    chk_acc(exp);
  endtask : pulse_result

  // ctl = {round, signed, sum, minus}; w picks the operand strobes
  // an unstrobed operand sees inverted data, so a false capture shows
  task automatic do_op(input logic [7:0] a, input logic [7:0] b, input logic [3:0] ctl,
                       input logic [1:0] w);
    @(negedge ref_clk);
    a_data = w[0] ? a : ~a;
    b_data = w[1] ? b : ~b;
    {rnd, sgn, sum, minus} = ctl;
    {b_stb, a_stb} = w;
    @(negedge ref_clk);
    {b_stb, a_stb} = 2'b00;
    if (w[0])
      m_a = a;
    if (w[1])
      m_b = b;
    m_ctl = ctl;
    m_acc = next_acc();
    pulse_result(m_acc);
  endtask : do_op

  // preload disabled sections from the pins, others keep their value
  task automatic preload(input logic [NSEC-1:0] d, input logic [ACCW-1:0] v);
    logic [ACCW-1:0] keep;
    @(negedge ref_clk);
    prel = 1'b1;
    drive_n = d;
    host_val = v;
    @(negedge ref_clk);
    chk_oe(3'h7);
    keep = {{3{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    m_acc = (v & keep) | (m_acc & ~keep);
    pulse_result(m_acc);
    prel = 1'b0;
  endtask : preload

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    repeat (12) @(negedge ref_clk);
    chk_oe(3'h7);
    reset_n = 1'b1;
    // every control combination, first one a direct load
    for (int c = 0; c < 16; c++) begin
      do_op(8'h80, 8'h7f, c[3:0], 2'b11);
      do_op(8'hff, 8'h03, c[3:0], 2'b11);
    end
    $display("test modes done");
    // one operand strobe at a time, controls follow either
    do_op(8'h05, 8'h00, 4'h0, 2'b01);
    do_op(8'h00, 8'hf9, 4'h6, 2'b10);
    // b rising while a stays high: no new control edge, no a recapture
    @(negedge ref_clk);
    a_data = 8'h04;
    {rnd, sgn, sum, minus} = 4'h0;
    a_stb = 1'b1;
    @(negedge ref_clk);
    a_data = 8'h09;
    b_data = 8'h06;
    {rnd, sgn, sum, minus} = 4'ha;
    b_stb = 1'b1;
    @(negedge ref_clk);
    {b_stb, a_stb} = 2'b00;
    m_a = 8'h04;
    m_b = 8'h06;
    m_ctl = 4'h0;
    m_acc = next_acc();
    pulse_result(m_acc);
    $display("test strobes done");
    // section enables outside preload
    for (int d = 0; d < 8; d++) begin
      @(negedge ref_clk);
      drive_n = d[2:0];
      @(negedge ref_clk);
      chk_oe(d[2:0]);
    end
    $display("test enables done");
    // preload every section pattern, then accumulate on top
    for (int d = 0; d < 8; d++)
      preload(d[2:0], 19'h5a5a5 ^ {16'h0000, d[2:0]});
    drive_n = 3'h0;
    do_op(8'h02, 8'h03, 4'h2, 2'b11);
    $display("test preload done");
    close_out();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : mult_accumulator_8x8_test
